/* verilog/tpg_pkg.sv */
// constants, register map and state encodings of the test pattern frame generator
// assumes one 20 MHz clock and an 8-bit indirect register port in front of the block
package tpg_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] OFS_CONTROL      = 8'h01;
    localparam logic [7:0] OFS_CONFIG       = 8'h02;
    localparam logic [7:0] OFS_CHANNEL_TYPE = 8'h03;
    localparam logic [7:0] OFS_LINE_HI      = 8'h04;
    localparam logic [7:0] OFS_LINE_LO      = 8'h05;
    localparam logic [7:0] OFS_BAR_HI       = 8'h06;
    localparam logic [7:0] OFS_BAR_LO       = 8'h07;
    localparam logic [7:0] OFS_ACT_HI       = 8'h08;
    localparam logic [7:0] OFS_ACT_LO       = 8'h09;
    localparam logic [7:0] OFS_TOT_HI       = 8'h0A;
    localparam logic [7:0] OFS_TOT_LO       = 8'h0B;
    localparam logic [7:0] OFS_PERIOD_HI    = 8'h0C;
    localparam logic [7:0] OFS_PERIOD_LO    = 8'h0D;
    localparam logic [7:0] OFS_TOP_BLANK    = 8'h0E;
    localparam logic [7:0] OFS_BOTTOM_BLANK = 8'h0F;
    localparam logic [7:0] OFS_LAST         = 8'h0F;

    // ==========================================================
    // values after reset, indexed by offset
    localparam logic [7:0] RESET_VALUES [0:15] = '{
        8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hF0,
        8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67, 8'h21, 8'h0A
    };

    // ==========================================================
    // field positions
    localparam int ENABLE_BIT   = 0;
    localparam int FIXED_BIT    = 7;
    localparam int BARS_HI      = 5;
    localparam int BARS_LO      = 4;
    localparam int BLOCK_HI     = 3;
    localparam int BLOCK_LO     = 0;
    localparam int VC_HI        = 7;
    localparam int VC_LO        = 6;
    localparam int DT_HI        = 5;
    localparam int DT_LO        = 0;

    // ==========================================================
    // packet codes and byte values
    localparam logic [5:0] DT_FRAME_START = 6'h00;
    localparam logic [5:0] DT_FRAME_END   = 6'h01;
    localparam logic [7:0] COLOUR_TABLE [0:7] = '{
        8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80
    };

    // ==========================================================
    // timing
    localparam int          UNIT_NS       = 10;
    localparam int          CLK_NS        = 50;
    localparam logic [16:0] UNITS_PER_CLK = 17'(CLK_NS / UNIT_NS);

    // ==========================================================
    // buffering
    localparam int FIFO_WIDTH = 10;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // packet emitter states, gray along id, count low, count high, payload
    typedef enum logic [2:0] {
        TPG_EM_IDLE = 3'b000,
        TPG_EM_ID   = 3'b001,
        TPG_EM_WCL  = 3'b011,
        TPG_EM_WCH  = 3'b010,
        TPG_EM_PAY  = 3'b110
    } tpg_emit_t;

endpackage : tpg_pkg

/* verilog/tpg_frame_timing.sv */
// test pattern frame generator: registers, frame and line timing, packet bytes, output fifo
// assumes synchronous inputs on mclk_i and a packet sink with valid/ready handshake
// Functional notes
// (RULE1) Virtual channel setting goes into every packet header, resets to zero.
// (RULE2) Data type setting goes into line packets, resets to RGB888 code.
// (RULE3) Sixteen-bit line size from two bytes is active line length, default 1920.
// (RULE4) Bar size sets width of every bar except the last one.
// (RULE5) Final bar fills remaining bytes up to the active line length.
// (RULE6) Sixteen-bit active line count per frame, default 480 lines.
// (RULE7) Sixteen-bit total line count sizes the frame, including blanking.
// (RULE8) Line starts spaced by line period in 10 ns units, default 31.75 us; here a due line start waits until the emitter has finished the previous packet.
// (RULE9) Top blank lines between frame start packet and first video line.
// (RULE10) Bottom blank lines between last video line and frame end packet.
// (RULE11) Generator runs only while control bit 0 is one.
// (RULE12) Config bit 7 picks colour bars or repeating fixed colour bytes.
// (RULE13) Bar count code 0..3 gives 1, 2, 4 or 8 bars, reset eight.
// (RULE14) Frames repeat while enabled; leftover lines up to total are idle.
// (RULE15) Multi-byte settings captured together at each frame boundary.

// ==========================================================
// fifo
module tpg_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              empty = (wr_ptr == rd_ptr);
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              push  = in_valid_i && !full;
    wire              pop   = out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
        end
    end
endmodule // tpg_fifo

// ==========================================================
// top
module tpg_frame_timing
    import tpg_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            pkt_valid_o,
    input  wire logic       pkt_ready_i,
    output logic      [7:0] pkt_data_o,
    output logic            pkt_first_o,
    output logic            pkt_last_o,
    output logic            frame_active_o
);

    function automatic logic [15:0] pair(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    function automatic logic [3:0] bar_total(input logic [1:0] code);
        return 4'(1 << code);
    endfunction

    // ==========================================================
    // register file
    logic [7:0] regs [0:15];
    wire        addr_hit = (reg_addr_i <= OFS_LAST);
    wire  [3:0] addr_idx = reg_addr_i[3:0];
    // offset 0 holds no register, so writes there are dropped
    wire        wr_hit   = reg_wr_i && addr_hit && (addr_idx != 4'h0);

    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < 16; i++) begin
            if (rst_i) begin
                regs[i] <= RESET_VALUES[i];
            end else if (wr_hit && addr_idx == 4'(i)) begin
                regs[i] <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= addr_hit ? regs[addr_idx] : 8'h00;
        end
    end

    // (RULE11) enable bit
    wire enable = regs[OFS_CONTROL[3:0]][ENABLE_BIT];

    // ==========================================================
    // frame shadow
    logic [7:0]  sh_ctype;
    logic [7:0]  sh_config;
    logic [15:0] sh_line;
    logic [15:0] sh_bar;
    logic [15:0] sh_act;
    logic [15:0] sh_tot;
    logic [15:0] sh_period;
    logic [7:0]  sh_top;
    logic [7:0]  sh_bottom;

    logic        running;
    logic [16:0] unit_acc;
    logic [16:0] line_idx;
    tpg_emit_t   estate;

    wire        emit_busy  = (estate != TPG_EM_IDLE);
    // (RULE8) line period in 10 ns units
    wire        line_due   = (unit_acc + UNITS_PER_CLK >= {1'b0, sh_period});
    wire        take       = running && line_due && !emit_busy;
    wire [16:0] first_vid  = 17'(sh_top) + 17'd1;
    wire [16:0] after_vid  = first_vid + 17'(sh_act);
    wire [16:0] fe_line    = after_vid + 17'(sh_bottom);
    // (RULE9) video after top blanking
    wire        is_fs      = (line_idx == 17'd0);
    wire        is_video   = (line_idx >= first_vid) && (line_idx < after_vid);
    // (RULE10) frame end after bottom blanking
    wire        is_fe      = (line_idx == fe_line);
    // (RULE14) wrap after frame end and total count
    wire        wrap       = (line_idx >= fe_line) && (line_idx + 17'd1 >= 17'(sh_tot));
    wire        load_sh    = (!running && enable) || (take && wrap);

    // (RULE15) coherent capture at frame boundary
    always_ff @(posedge mclk_i) begin
        if (rst_i || load_sh) begin
            sh_ctype  <= regs[OFS_CHANNEL_TYPE[3:0]];
            sh_config <= regs[OFS_CONFIG[3:0]];
            // (RULE3) line length pair
            sh_line   <= pair(regs[OFS_LINE_HI[3:0]], regs[OFS_LINE_LO[3:0]]);
            sh_bar    <= pair(regs[OFS_BAR_HI[3:0]], regs[OFS_BAR_LO[3:0]]);
            // (RULE6) active line pair
            sh_act    <= pair(regs[OFS_ACT_HI[3:0]], regs[OFS_ACT_LO[3:0]]);
            // (RULE7) total line pair
            sh_tot    <= pair(regs[OFS_TOT_HI[3:0]], regs[OFS_TOT_LO[3:0]]);
            sh_period <= pair(regs[OFS_PERIOD_HI[3:0]], regs[OFS_PERIOD_LO[3:0]]);
            sh_top    <= regs[OFS_TOP_BLANK[3:0]];
            sh_bottom <= regs[OFS_BOTTOM_BLANK[3:0]];
        end
    end

    // ==========================================================
    // line timing
    // dropping enable clears timing at once; bytes already queued still drain
    always_ff @(posedge mclk_i) begin
        if (rst_i || !enable) begin
            running  <= 1'b0;
            unit_acc <= '0;
            line_idx <= '0;
        end else begin
            running <= 1'b1;
            if (take) begin
                unit_acc <= '0;
                line_idx <= wrap ? 17'd0 : line_idx + 17'd1;
            end else if (!line_due) begin
                unit_acc <= unit_acc + UNITS_PER_CLK;
            end
        end
    end

    // ==========================================================
    // packet emitter
    logic [5:0]  pkt_dt;
    logic        pkt_long;
    logic [15:0] pkt_wc;
    logic [15:0] pay_cnt;
    logic [15:0] bar_cnt;
    logic [2:0]  bar_idx;
    logic [3:0]  fix_idx;
    logic        push_ready;

    wire       push_valid = emit_busy;
    wire       advance    = push_valid && push_ready;
    wire       start_pkt  = take && (is_fs || is_video || is_fe);
    wire [1:0] vc         = sh_ctype[VC_HI:VC_LO];
    wire       fixed_sel  = sh_config[FIXED_BIT];
    wire [3:0] block_len  = sh_config[BLOCK_HI:BLOCK_LO];
    // (RULE13) bar count decode
    wire [2:0] last_bar   = 3'(bar_total(sh_config[BARS_HI:BARS_LO]) - 4'd1);
    wire       has_pay    = pkt_long && (pkt_wc != 16'h0000);
    wire       pay_last   = (pay_cnt + 16'd1 >= pkt_wc);
    // (RULE4) bar width reached before the last bar
    wire       bar_step   = (bar_cnt + 16'd1 >= sh_bar) && (bar_idx != last_bar);
    wire       fix_wrap   = (fix_idx + 4'd1 >= block_len);

    // (RULE12) colour bar or fixed colour bytes
    wire [7:0] pay_byte   = fixed_sel ? COLOUR_TABLE[fix_idx[2:0]] : COLOUR_TABLE[bar_idx];

    logic [7:0] push_byte;
    logic       push_first;
    logic       push_last;

    always_comb begin
        push_first = 1'b0;
        push_last  = 1'b0;
        case (estate)
            TPG_EM_ID: begin
                // (RULE1) channel in header
                push_byte  = {vc, pkt_dt};
                push_first = 1'b1;
            end
            TPG_EM_WCL: begin
                push_byte = pkt_wc[7:0];
            end
            TPG_EM_WCH: begin
                push_byte = pkt_wc[15:8];
                push_last = !has_pay;
            end
            TPG_EM_PAY: begin
                push_byte = pay_byte;
                push_last = pay_last;
            end
            default: begin
                push_byte = 8'h00;
            end
        endcase
    end

    tpg_emit_t next_estate;
    wire       line_pkt   = is_video && !is_fs && !is_fe;
    wire [5:0] line_dt    = sh_ctype[DT_HI:DT_LO];
    wire [5:0] next_dt    = is_fs ? DT_FRAME_START : (is_fe ? DT_FRAME_END : line_dt);

    // start_pkt only fires while idle, so a packet is never cut short by a new line
    always_comb begin
        next_estate = estate;
        if (start_pkt) begin
            next_estate = TPG_EM_ID;
        end else if (advance) begin
            case (estate)
                TPG_EM_ID: begin
                    next_estate = TPG_EM_WCL;
                end
                TPG_EM_WCL: begin
                    next_estate = TPG_EM_WCH;
                end
                TPG_EM_WCH: begin
                    next_estate = has_pay ? TPG_EM_PAY : TPG_EM_IDLE;
                end
                TPG_EM_PAY: begin
                    next_estate = pay_last ? TPG_EM_IDLE : TPG_EM_PAY;
                end
                default: begin
                    next_estate = TPG_EM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || !running) begin
            estate <= TPG_EM_IDLE;
        end else begin
            estate <= next_estate;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || !running) begin
            pkt_dt   <= DT_FRAME_START;
            pkt_long <= 1'b0;
            pkt_wc   <= '0;
        end else if (start_pkt) begin
            // (RULE2) data type for line packets
            pkt_dt   <= next_dt;
            pkt_long <= line_pkt;
            pkt_wc   <= line_pkt ? sh_line : 16'h0000;
        end
    end

    wire [15:0] next_pay_cnt = pay_cnt + 16'd1;
    wire [15:0] next_bar_cnt = bar_step ? 16'd0 : bar_cnt + 16'd1;
    wire  [2:0] next_bar_idx = bar_step ? bar_idx + 3'd1 : bar_idx;
    wire  [3:0] next_fix_idx = fix_wrap ? 4'd0 : fix_idx + 4'd1;

    // (RULE5) last bar runs to the line end
    always_ff @(posedge mclk_i) begin
        if (rst_i || estate != TPG_EM_PAY) begin
            pay_cnt <= '0;
            bar_cnt <= '0;
            bar_idx <= '0;
            fix_idx <= '0;
        end else if (advance) begin
            pay_cnt <= next_pay_cnt;
            bar_cnt <= next_bar_cnt;
            bar_idx <= next_bar_idx;
            fix_idx <= next_fix_idx;
        end
    end

    assign frame_active_o = running;

    // ==========================================================
    // output buffer
    logic [FIFO_WIDTH-1:0] fifo_out;

    tpg_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   ({push_first, push_last, push_byte}),
        .out_valid_o (pkt_valid_o),
        .out_ready_i (pkt_ready_i),
        .out_data_o  (fifo_out)
    );

    assign pkt_first_o = fifo_out[9];
    assign pkt_last_o  = fifo_out[8];
    assign pkt_data_o  = fifo_out[7:0];

endmodule // tpg_frame_timing

/* tb/tpg_frame_timing_properties.sv */
// port checker of the test pattern frame generator
// assumes it is bound onto tpg_frame_timing, one clock, sync reset
module tpg_frame_timing_properties (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       pkt_valid_o,
    input wire logic       pkt_ready_i,
    input wire logic [7:0] pkt_data_o,
    input wire logic       pkt_first_o,
    input wire logic       pkt_last_o,
    input wire logic       frame_active_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // packet tracking
    logic [16:0] cnt;
    logic [15:0] wc;
    logic [7:0]  wlo;
    logic [1:0]  vc_q;
    logic        short_q;
    wire         acc = pkt_valid_o && pkt_ready_i;
    wire  [16:0] idx = pkt_first_o ? 17'h0 : cnt;
    wire  [16:0] wc2 = {1'b0, wc} + 17'h2;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt     <= 17'h0;
            wc      <= 16'h0;
            wlo     <= 8'h00;
            vc_q    <= 2'h0;
            short_q <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'h03) vc_q <= reg_wdata_i[7:6];
            if (acc) cnt <= idx + 17'h1;
            if (acc && pkt_first_o) short_q <= pkt_data_o[5:1] == 5'h00;
            if (acc && idx == 17'h1) wlo <= pkt_data_o;
            if (acc && idx == 17'h2) wc <= {pkt_data_o, wlo};
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_on_wr;
        reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[0];
    endsequence
    sequence s_off_wr;
        reg_wr_i && reg_addr_i == 8'h01 && !reg_wdata_i[0];
    endsequence
    a_enable_starts_run: assert property (s_on_wr |-> ##[1:2] frame_active_o)
        else $error("generator did not start after enable");
    a_disable_stops_run: assert property (s_off_wr |-> ##[1:2] !frame_active_o)
        else $error("generator did not stop after disable");
    a_unmapped_read_zero: assert property (reg_rd_i && reg_addr_i > 8'h0F |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_stall_holds_byte: assert property (pkt_valid_o && !pkt_ready_i |=> pkt_valid_o
        && $stable(pkt_data_o) && $stable(pkt_first_o) && $stable(pkt_last_o))
        else $error("stalled byte changed");
    a_header_vc_field: assert property (acc && pkt_first_o && frame_active_o
        |-> pkt_data_o[7:6] == vc_q) else $error("wrong virtual channel");
    a_short_ends_third: assert property (acc && short_q && !pkt_first_o && cnt == 17'h2
        |-> pkt_last_o && pkt_data_o == 8'h00) else $error("short packet malformed");
    a_first_not_last: assert property (acc && pkt_first_o |-> !pkt_last_o)
        else $error("packet of one byte");
    a_long_ends_count: assert property (acc && !pkt_first_o && !short_q && cnt > 17'h2
        |-> pkt_last_o == (cnt == wc2)) else $error("long packet length wrong");
endmodule // tpg_frame_timing_properties

bind tpg_frame_timing tpg_frame_timing_properties tpg_frame_timing_properties_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pkt_valid_o(pkt_valid_o), .pkt_ready_i(pkt_ready_i), .pkt_data_o(pkt_data_o),
    .pkt_first_o(pkt_first_o), .pkt_last_o(pkt_last_o), .frame_active_o(frame_active_o));

/* tb/tpg_pkt_sink.sv */
// packet sink model standing at the forward packet path
// assumes valid/ready bytes on mclk_i; slow_i makes it stall at random
module tpg_pkt_sink (
    input  wire logic       mclk_i,
    input  wire logic       slow_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    input  wire logic       first_i,
    input  wire logic       last_i,
    output logic            ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] rx_q [$];
    int         t_q  [$];
    int         cyc = 0;
    initial ready_o = 1'b1;
    // keeps every accepted byte and the cycle of each packet start
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (valid_i && ready_o) begin
            rx_q.push_back({first_i, last_i, data_i});
            if (first_i) t_q.push_back(cyc);
        end
        ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
    end
endmodule // tpg_pkt_sink

/* tb/tpg_frame_timing_tb_top.sv */
// testbench of the frame generator: register port, frame content and line timing
// assumes the packet sink model and the bound port checker
module tpg_frame_timing_tb_top
    import tpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LB = 10, BAR = 2, BS = 3, ACT = 2, TOP = 1, BOT = 2, TOT = 9;
    localparam int PU = 200, P = PU * UNIT_NS / CLK_NS;
    localparam logic [7:0] DEF [16] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00,
        8'hF0, 8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67, 8'h21, 8'h0A};
    logic       mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, pkt_data_o;
    logic       pkt_valid_o, pkt_ready_i, pkt_first_o, pkt_last_o, frame_active_o;
    int         n_fail = 0, n_tests = 0;
    logic [9:0] exp_q [$];
    always #25 mclk_i = ~mclk_i;

    tpg_frame_timing tpg_frame_timing_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pkt_valid_o(pkt_valid_o),
        .pkt_ready_i(pkt_ready_i), .pkt_data_o(pkt_data_o), .pkt_first_o(pkt_first_o),
        .pkt_last_o(pkt_last_o), .frame_active_o(frame_active_o));
    tpg_pkt_sink tpg_pkt_sink_inst (.mclk_i(mclk_i), .slow_i(slow), .valid_i(pkt_valid_o),
        .data_i(pkt_data_o), .first_i(pkt_first_o), .last_i(pkt_last_o),
        .ready_o(pkt_ready_i));

    // ==========================================================
    // tasks
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 8'h01, d[7:0]);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(posedge mclk_i);
        #1 chk(16'(reg_rdata_o), 16'(e));
    endtask
    function automatic void short3(input logic [7:0] id);
        exp_q.push_back({2'b10, id});
        exp_q.push_back(10'h000);
        exp_q.push_back(10'h100);
    endfunction
    // one frame and the next frame start, as the sink should see them
    task automatic model(input logic [1:0] vc, input logic [5:0] dt, input bit fixed,
        input int nb);
        exp_q = {};
        short3({vc, DT_FRAME_START});
        for (int l = 0; l < ACT; l++) begin
            exp_q.push_back({2'b10, vc, dt});
            exp_q.push_back({2'b00, 8'(LB)});
            exp_q.push_back({2'b00, 8'(LB >> 8)});
            for (int i = 0; i < LB; i++)
                exp_q.push_back({1'b0, i == LB - 1, fixed ? COLOUR_TABLE[i % BS]
                    : COLOUR_TABLE[(i / BAR < nb) ? i / BAR : nb - 1]});
        end
        short3({vc, DT_FRAME_END});
        short3({vc, DT_FRAME_START});
    endtask

    initial begin
        #(CLK_NS * 20000);
        n_fail++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [1:0] vc;
        logic [5:0] dt;
        logic [7:0] d;
        logic [1:0] code;
        int         k;
        int         n;
        void'($urandom(18));
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 16; a++) rdc(8'(a), DEF[a]);
        wr(8'h10, 8'h5A);
        rdc(8'h10, 8'h00);
        for (int a = 3; a < 16; a++) begin
            d = 8'($urandom);
            wr(8'(a), d);
            rdc(8'(a), d);
        end
        // every bar count code once in the first four rounds, fixed colours in the last round
        for (int r = 0; r < 5; r++) begin
            vc = 2'($urandom);
            dt = 6'($urandom_range(63, 2));
            code = 2'(r + 2);
            wr16(OFS_LINE_HI, 16'(LB));
            wr16(OFS_BAR_HI, 16'(BAR));
            wr16(OFS_ACT_HI, 16'(ACT));
            wr16(OFS_TOT_HI, 16'(TOT));
            wr16(OFS_PERIOD_HI, 16'(PU));
            wr(OFS_TOP_BLANK, 8'(TOP));
            wr(OFS_BOTTOM_BLANK, 8'(BOT));
            wr(OFS_CONFIG, {r == 4, 1'b0, code, 4'(BS)});
            wr(OFS_CHANNEL_TYPE, {vc, dt});
            model(vc, dt, r == 4, 1 << code);
            slow <= (r != 0);
            tpg_pkt_sink_inst.rx_q = {};
            tpg_pkt_sink_inst.t_q = {};
            wr(OFS_CONTROL, 8'h01);
            k = 0;
            while (tpg_pkt_sink_inst.rx_q.size() < exp_q.size() && k < 4000) begin
                @(posedge mclk_i);
                k++;
            end
            chk(16'(k < 4000), 16'h0001);
            chk(16'(frame_active_o), 16'h0001);
            wr(OFS_CONTROL, 8'h00);
            for (int i = 0; i < exp_q.size(); i++)
                chk(16'(tpg_pkt_sink_inst.rx_q[i]), 16'(exp_q[i]));
            if (r == 0) begin
                chk(16'(tpg_pkt_sink_inst.t_q[1] - tpg_pkt_sink_inst.t_q[0]), 16'((TOP + 1) * P));
                chk(16'(tpg_pkt_sink_inst.t_q[2] - tpg_pkt_sink_inst.t_q[1]), 16'(P));
                chk(16'(tpg_pkt_sink_inst.t_q[3] - tpg_pkt_sink_inst.t_q[2]), 16'((BOT + 1) * P));
                chk(16'(tpg_pkt_sink_inst.t_q[4] - tpg_pkt_sink_inst.t_q[0]), 16'(TOT * P));
            end
            repeat (40) @(posedge mclk_i);
            chk(16'(frame_active_o), 16'h0000);
            n = tpg_pkt_sink_inst.rx_q.size();
            repeat (3 * P) @(posedge mclk_i);
            chk(16'(tpg_pkt_sink_inst.rx_q.size()), 16'(n));
        end
        tally_and_finish();
    end
endmodule // tpg_frame_timing_tb_top
